// ==== rtl/hbi_pkg.sv ====
// Shared constants and types for the H-bridge input control block
package hbi_pkg;

  // Control mode field encodings
  localparam logic [1:0] HBI_MODE_PHASE_ENABLE_MODE = 2'h0;
  localparam logic [1:0] HBI_MODE_PWM   = 2'h1;
  localparam logic [1:0] HBI_MODE_INDEP = 2'h2;
  localparam logic [1:0] HBI_MODE_OFF   = 2'h3;
  localparam logic [1:0] HBI_MODE_RESET = HBI_MODE_PWM;

  // Mode strap sense codes from the strap level detector
  localparam logic [1:0] HBI_STRAP_GND    = 2'h0;
  localparam logic [1:0] HBI_STRAP_RES    = 2'h1;
  localparam logic [1:0] HBI_STRAP_SUPPLY = 2'h2;

  // Register byte offsets
  localparam logic [3:0] HBI_OFS_CTRL_ONE   = 4'h0;
  localparam logic [3:0] HBI_OFS_CTRL_THREE = 4'h4;
  localparam logic [3:0] HBI_OFS_STATUS     = 4'h8;

  // Field positions
  localparam int HBI_CTRL1_MODE_LSB  = 0;
  localparam int HBI_CTRL3_FLOAT_A   = 0;
  localparam int HBI_CTRL3_FLOAT_B   = 1;
  localparam int HBI_ST_ACT_MODE_LSB = 0;
  localparam int HBI_ST_PEND_LSB     = 2;
  localparam int HBI_ST_IN_A         = 4;
  localparam int HBI_ST_IN_B         = 5;
  localparam int HBI_ST_SLEEP_LOW    = 6;
  localparam int HBI_ST_DISABLE      = 7;
  localparam int HBI_ST_FAULT_A      = 8;
  localparam int HBI_ST_FAULT_B      = 9;
  localparam int HBI_ST_AWAKE        = 10;
  localparam int HBI_ST_OE_A         = 11;
  localparam int HBI_ST_OE_B         = 12;

  // Reset values
  localparam logic       HBI_FLOAT_RESET = 1'b0;
  localparam logic [31:0] HBI_RDATA_IDLE = 32'h0000_0000;

  // Power sequencing states
  typedef enum logic [1:0] {
    HBI_PWR_WAIT,
    HBI_PWR_AWAKE,
    HBI_PWR_ASLEEP
  } hbi_pwr_t;

endpackage

// ==== rtl/hbi_sync.sv ====
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none
module hbi_sync
  import hbi_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } hbi_sync_t;

  hbi_sync_t st_r;
  hbi_sync_t st_nxt;

  // First stage only feeds the second stage
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = async_in;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.sync;

endmodule
`default_nettype wire

// ==== rtl/hbi_decode.sv ====
// Truth-table decode from logic inputs to bridge output drive
`timescale 1ns/10ps
`default_nettype none
module hbi_decode
  import hbi_pkg::*;
(
  input  wire logic [1:0] mode,
  input  wire logic       active,
  input  wire logic       in_a,
  input  wire logic       in_b,
  input  wire logic       fault_a,
  input  wire logic       fault_b,
  input  wire logic       float_a,
  input  wire logic       float_b,
  output logic            drv_a,
  output logic            oe_a,
  output logic            drv_b,
  output logic            oe_b
);

  // Pure level decode; outputs follow every input change
  always_comb begin
    drv_a = 1'b0;
    oe_a  = 1'b0;
    drv_b = 1'b0;
    oe_b  = 1'b0;
    if (active) begin
      case (mode)
        HBI_MODE_PHASE_ENABLE_MODE: begin
          oe_a  = 1'b1;
          oe_b  = 1'b1;
          drv_a = !in_a || in_b;
          drv_b = !in_a || !in_b;
        end
        HBI_MODE_PWM: begin
          oe_a  = in_a || in_b;
          oe_b  = in_a || in_b;
          drv_a = in_a;
          drv_b = in_b;
        end
        HBI_MODE_INDEP: begin
          // Each half keeps running while the other is faulted or floated
          oe_a  = !fault_a && !float_a;
          oe_b  = !fault_b && !float_b;
          drv_a = in_a;
          drv_b = in_b;
        end
        default: begin
          oe_a = 1'b0;
          oe_b = 1'b0;
        end
      endcase
      // Outside independent mode a fault in either half stops the bridge
      if (mode != HBI_MODE_INDEP && (fault_a || fault_b)) begin
        oe_a = 1'b0;
        oe_b = 1'b0;
      end
    end
    if (!oe_a) begin
      drv_a = 1'b0;
    end
    if (!oe_b) begin
      drv_b = 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/hbi_top.sv ====
// H-bridge input control: mode selection, latching, output decode, register slave
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Mode field 00/01/10 selects PE/PWM/independent
// - Mode 11 ignores inputs, floats both outputs
// - Strap ground/supply/resistor picks PE/PWM/independent
// - Strap captured at power-up, sleep exit only
// - Written mode applied on disable falling edge
// - Sleep low or disable high floats outputs
// - Phase/enable truth table
// - PWM truth table
// - Independent mode: each output follows input
// - Independent fault floats only faulted half
// - Float bits force output high-impedance in independent mode only
// - Float bits exist only in register variant
// - Outputs follow static or PWM inputs
module hbi_top
  import hbi_pkg::*;
#(
  parameter logic REG_VARIANT = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        sleep_request_low,
  input  wire logic        disable_in,
  input  wire logic        logic_input_a,
  input  wire logic        logic_input_b,
  input  wire logic        overcurrent_fault_a,
  input  wire logic        overcurrent_fault_b,
  input  wire logic        internal_logic_supply,
  input  wire logic [1:0]  mode_strap_sense,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             bridge_output_a,
  output logic             bridge_output_a_oe,
  output logic             bridge_output_b,
  output logic             bridge_output_b_oe
);

  //////////////////////////////////////////////////////////////////////////
  // State record

  typedef struct packed {
    hbi_pwr_t    pwr;
    logic [1:0]  pend_mode;
    logic [1:0]  act_mode;
    logic        float_a;
    logic        float_b;
    logic        dis_prev;
    logic        waitreq;
    logic [31:0] rdata;
    logic        out_a;
    logic        out_a_oe;
    logic        out_b;
    logic        out_b_oe;
  } hbi_top_t;

  hbi_top_t st_r;
  hbi_top_t st_nxt;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int SYNC_W = 9;

  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_sync;
  logic              sleep_low_s;
  logic              disable_s;
  logic              in_a_s;
  logic              in_b_s;
  logic              fault_a_s;
  logic              fault_b_s;
  logic              supply_s;
  logic [1:0]        strap_s;

  // All pins share one synchroniser bank; strap bits may skew by a cycle
  assign pins_async = {mode_strap_sense, internal_logic_supply, overcurrent_fault_b,
                       overcurrent_fault_a, logic_input_b, logic_input_a, disable_in,
                       sleep_request_low};

  hbi_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  // Named views of the synchronised pins
  assign sleep_low_s = pins_sync[0];
  assign disable_s   = pins_sync[1];
  assign in_a_s      = pins_sync[2];
  assign in_b_s      = pins_sync[3];
  assign fault_a_s   = pins_sync[4];
  assign fault_b_s   = pins_sync[5];
  assign supply_s    = pins_sync[6];
  assign strap_s     = pins_sync[8:7];

  //////////////////////////////////////////////////////////////////////////
  // Output decode

  logic dec_drv_a;
  logic dec_oe_a;
  logic dec_drv_b;
  logic dec_oe_b;
  logic bridge_active;
  logic float_a_eff;
  logic float_b_eff;

  // Active only when awake, sleep released and disable low
  assign bridge_active = (st_r.pwr == HBI_PWR_AWAKE) && sleep_low_s && !disable_s;

  // The strap variant has no per-half float control at all
  assign float_a_eff = REG_VARIANT && st_r.float_a;
  assign float_b_eff = REG_VARIANT && st_r.float_b;

  hbi_decode u_decode (
    .mode    (st_r.act_mode),
    .active  (bridge_active),
    .in_a    (in_a_s),
    .in_b    (in_b_s),
    .fault_a (fault_a_s),
    .fault_b (fault_b_s),
    .float_a (float_a_eff),
    .float_b (float_b_eff),
    .drv_a   (dec_drv_a),
    .oe_a    (dec_oe_a),
    .drv_b   (dec_drv_b),
    .oe_b    (dec_oe_b)
  );

  //////////////////////////////////////////////////////////////////////////
  // Strap decode

  logic [1:0] strap_mode;

  // Unknown detector code falls back to PWM, the same as the reset mode
  always_comb begin
    if (strap_s == HBI_STRAP_GND) begin
      strap_mode = HBI_MODE_PHASE_ENABLE_MODE;
    end else if (strap_s == HBI_STRAP_RES) begin
      strap_mode = HBI_MODE_INDEP;
    end else if (strap_s == HBI_STRAP_SUPPLY) begin
      strap_mode = HBI_MODE_PWM;
    end else begin
      strap_mode = HBI_MODE_PWM;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus access qualifiers

  logic       bus_req;
  logic       bus_commit;
  logic       wr_commit;
  logic [3:0] word_addr;

  // Request is seen while waitrequest is high, committed when it is low
  assign bus_req    = avs_read || avs_write;
  assign bus_commit = bus_req && !st_r.waitreq;
  assign wr_commit  = avs_write && !st_r.waitreq && avs_byteenable[0];
  assign word_addr  = {avs_address[3:2], 2'b00};

  //////////////////////////////////////////////////////////////////////////
  // Read mux

  logic [31:0] rd_value;

  // Unmapped offsets read as zero
  always_comb begin
    rd_value = HBI_RDATA_IDLE;
    if (word_addr == HBI_OFS_CTRL_ONE) begin
      if (REG_VARIANT) begin
        rd_value[HBI_CTRL1_MODE_LSB +: 2] = st_r.pend_mode;
      end
    end else if (word_addr == HBI_OFS_CTRL_THREE) begin
      if (REG_VARIANT) begin
        rd_value[HBI_CTRL3_FLOAT_A] = st_r.float_a;
        rd_value[HBI_CTRL3_FLOAT_B] = st_r.float_b;
      end
    end else if (word_addr == HBI_OFS_STATUS) begin
      rd_value[HBI_ST_ACT_MODE_LSB +: 2] = st_r.act_mode;
      rd_value[HBI_ST_PEND_LSB +: 2]     = st_r.pend_mode;
      rd_value[HBI_ST_IN_A]              = in_a_s;
      rd_value[HBI_ST_IN_B]              = in_b_s;
      rd_value[HBI_ST_SLEEP_LOW]         = sleep_low_s;
      rd_value[HBI_ST_DISABLE]           = disable_s;
      rd_value[HBI_ST_FAULT_A]           = fault_a_s;
      rd_value[HBI_ST_FAULT_B]           = fault_b_s;
      rd_value[HBI_ST_AWAKE]             = (st_r.pwr == HBI_PWR_AWAKE);
      rd_value[HBI_ST_OE_A]              = st_r.out_a_oe;
      rd_value[HBI_ST_OE_B]              = st_r.out_b_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic dis_fall;
  logic strap_capture;

  // Edge seen on the synchronised disable level
  assign dis_fall = st_r.dis_prev && !disable_s;

  always_comb begin
    st_nxt        = st_r;
    strap_capture = 1'b0;

    st_nxt.dis_prev = disable_s;

    // Power sequencing: supply and sleep release first, then strap latch on the same edge as awake
    case (st_r.pwr)
      HBI_PWR_WAIT: begin
        if (supply_s && sleep_low_s) begin
          strap_capture = 1'b1;
          st_nxt.pwr    = HBI_PWR_AWAKE;
        end
      end
      HBI_PWR_AWAKE: begin
        if (!supply_s) begin
          st_nxt.pwr = HBI_PWR_WAIT;
        end else if (!sleep_low_s) begin
          st_nxt.pwr = HBI_PWR_ASLEEP;
        end
      end
      HBI_PWR_ASLEEP: begin
        if (!supply_s) begin
          st_nxt.pwr = HBI_PWR_WAIT;
        end else if (sleep_low_s) begin
          strap_capture = 1'b1;
          st_nxt.pwr    = HBI_PWR_AWAKE;
        end
      end
      default: begin
        st_nxt.pwr = HBI_PWR_WAIT;
      end
    endcase

    // Active mode moves only at its latch event, never on a raw write
    if (REG_VARIANT) begin
      if (dis_fall) begin
        st_nxt.act_mode = st_r.pend_mode;
      end
    end else if (strap_capture) begin
      st_nxt.act_mode = strap_mode;
    end

    // Register writes land at the edge where waitrequest is sampled low
    if (wr_commit && REG_VARIANT) begin
      if (word_addr == HBI_OFS_CTRL_ONE) begin
        st_nxt.pend_mode = avs_writedata[HBI_CTRL1_MODE_LSB +: 2];
      end else if (word_addr == HBI_OFS_CTRL_THREE) begin
        st_nxt.float_a = avs_writedata[HBI_CTRL3_FLOAT_A];
        st_nxt.float_b = avs_writedata[HBI_CTRL3_FLOAT_B];
      end
    end

    // One wait cycle per access; keeps read data stable for the commit edge
    if (bus_commit) begin
      st_nxt.waitreq = 1'b1;
    end else if (bus_req) begin
      st_nxt.waitreq = 1'b0;
      st_nxt.rdata   = rd_value;
    end else begin
      st_nxt.waitreq = 1'b1;
    end

    // Outputs registered so pins never glitch on decode hazards
    st_nxt.out_a    = dec_drv_a;
    st_nxt.out_a_oe = dec_oe_a;
    st_nxt.out_b    = dec_drv_b;
    st_nxt.out_b_oe = dec_oe_b;
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r           <= '0;
      st_r.pwr       <= HBI_PWR_WAIT;
      st_r.pend_mode <= HBI_MODE_RESET;
      st_r.act_mode  <= HBI_MODE_RESET;
      st_r.float_a   <= HBI_FLOAT_RESET;
      st_r.float_b   <= HBI_FLOAT_RESET;
      st_r.waitreq   <= 1'b1;
      st_r.rdata     <= HBI_RDATA_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop

  assign avs_readdata       = st_r.rdata;
  assign avs_waitrequest    = st_r.waitreq;
  assign bridge_output_a    = st_r.out_a;
  assign bridge_output_a_oe = st_r.out_a_oe;
  assign bridge_output_b    = st_r.out_b;
  assign bridge_output_b_oe = st_r.out_b_oe;

endmodule
`default_nettype wire

// ==== testbench/hbi_top_asserts.sv ====
// Port-level checker for the H-bridge input control top
`timescale 1ns/10ps
`default_nettype none
module hbi_top_asserts
  import hbi_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        sleep_request_low,
  input wire logic        disable_in,
  input wire logic        logic_input_a,
  input wire logic        logic_input_b,
  input wire logic        overcurrent_fault_a,
  input wire logic        overcurrent_fault_b,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        bridge_output_a,
  input wire logic        bridge_output_a_oe,
  input wire logic        bridge_output_b,
  input wire logic        bridge_output_b_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // Quiet counter; the long margin covers sync plus the latch delay
  wire logic [5:0] pins = {sleep_request_low, disable_in, logic_input_a, logic_input_b,
                           overcurrent_fault_a, overcurrent_fault_b};
  logic [5:0] pins_r;
  logic [3:0] quiet_r;
  always_ff @(posedge clk) begin
    pins_r <= pins;
    if (reset || avs_write || pins != pins_r) quiet_r <= 4'h0;
    else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
  end
  ////////////////////////////////////////
  a_sleep_floats: assert property (
    !sleep_request_low [*3] |=> !bridge_output_a_oe && !bridge_output_b_oe)
    else $error("output driven while asleep");
  a_disable_floats: assert property (
    disable_in [*3] |=> !bridge_output_a_oe && !bridge_output_b_oe)
    else $error("output driven while disabled");
  a_fault_a_floats: assert property (
    overcurrent_fault_a [*3] |=> !bridge_output_a_oe)
    else $error("faulted half A still driven");
  a_fault_b_floats: assert property (
    overcurrent_fault_b [*3] |=> !bridge_output_b_oe)
    else $error("faulted half B still driven");
  a_quiet_outputs_hold: assert property (
    quiet_r >= 4'h8 |-> $stable({bridge_output_a, bridge_output_a_oe,
                                 bridge_output_b, bridge_output_b_oe}))
    else $error("outputs moved with no cause");
  a_bus_answers: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_idle_waits: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  a_rdata_on_answer: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
    else $error("read data changed outside an answer");
endmodule
bind hbi_top hbi_top_asserts chk_u (
  .clk(clk), .reset(reset), .sleep_request_low(sleep_request_low),
  .disable_in(disable_in), .logic_input_a(logic_input_a), .logic_input_b(logic_input_b),
  .overcurrent_fault_a(overcurrent_fault_a), .overcurrent_fault_b(overcurrent_fault_b),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .bridge_output_a(bridge_output_a),
  .bridge_output_a_oe(bridge_output_a_oe), .bridge_output_b(bridge_output_b),
  .bridge_output_b_oe(bridge_output_b_oe));
`default_nettype wire

// ==== testbench/hbi_ctrl_model.sv ====
// Model of the motor controller that drives the logic pins
`timescale 1ns/10ps
`default_nettype none
module hbi_ctrl_model (
  input  wire logic       clk,
  input  wire logic [3:0] cmd,
  input  wire logic       fwd,
  output logic            sleep_low,
  output logic            dis,
  output logic            in_a,
  output logic            in_b
);
  logic [2:0] ph_r = 3'h0;
  initial {sleep_low, dis, in_a, in_b} = 4'h8;
  // Pins move just after an edge, as a clocked controller would
  always @(posedge clk) begin
    ph_r <= ph_r + 3'h1;
    {sleep_low, dis, in_a, in_b} <= cmd;
    // Forward drive: A held high, B alternates drive and brake
    if (fwd) begin
      in_a <= 1'b1;
      in_b <= ph_r[2];
    end
  end
endmodule
`default_nettype wire

// ==== testbench/test_hbi_top.sv ====
// Self-checking bench for the H-bridge input control block
`timescale 1ns/10ps
`default_nettype none
module test_hbi_top
  import hbi_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, fwd = 1'b0, flt_a = 1'b0, flt_b = 1'b0;
  logic rd = 1'b0, wr = 1'b0, wreq, oa, oea, ob, oeb, sl, dis, ia, ib;
  logic [3:0] cmd = 4'h8, addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic [1:0] mode_r = HBI_MODE_RESET, fl = 2'h0;
  logic [9:0] r;
  int mismatches = 0, checked = 0, n;
  always #25 clk = ~clk;
  hbi_ctrl_model ctrl_u (.clk(clk), .cmd(cmd), .fwd(fwd), .sleep_low(sl), .dis(dis),
    .in_a(ia), .in_b(ib));
  hbi_top dut_u (.clk(clk), .reset(reset), .sleep_request_low(sl), .disable_in(dis),
    .logic_input_a(ia), .logic_input_b(ib), .overcurrent_fault_a(flt_a),
    .overcurrent_fault_b(flt_b), .internal_logic_supply(1'b1), .mode_strap_sense(2'h0),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .bridge_output_a(oa), .bridge_output_a_oe(oea), .bridge_output_b(ob),
    .bridge_output_b_oe(oeb));
  ////////////////////////////////////////
  task automatic results;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: value %h, wanted %h", $time, g, e);
    end
  endtask
  // Expected {oe_a, a, oe_b, b}; any fault outside independent mode floats both
  function automatic logic [3:0] expect_out(input logic [1:0] m, input logic [3:0] c);
    logic [3:0] e;
    logic a, b;
    {a, b} = c[1:0];
    e = 4'h0;
    if (c[3] && !c[2] && !((flt_a || flt_b) && m != HBI_MODE_INDEP))
      case (m)
        HBI_MODE_PHASE_ENABLE_MODE: e = {1'b1, !a || b, 1'b1, !a || !b};
        HBI_MODE_PWM: e = (a || b) ? {1'b1, a, 1'b1, b} : 4'h0;
        HBI_MODE_INDEP: e = {!flt_a && !fl[0], a && !flt_a && !fl[0],
                             !flt_b && !fl[1], b && !flt_b && !fl[1]};
        default: e = 4'h0;
      endcase
    return e;
  endfunction
  task automatic cmp_out;
    cmp_reg({28'h0, oea, oa, oeb, ob}, {28'h0, expect_out(mode_r, cmd)});
  endtask
  // Pin change takes about three edges; eight leaves room for the mode latch
  task automatic step(input logic [3:0] c, input logic fa, input logic fb);
    cmd <= c;
    flt_a <= fa;
    flt_b <= fb;
    repeat (8) @(posedge clk);
  endtask
  // One bus transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      $display("unexpected at %0t: bus timeout", $time);
      results();
    end
    @(posedge clk);
  endtask
  // Settle disable low first, so a random high disable cannot latch the new write early
  task automatic latch(input logic [1:0] m);
    step(4'h8, 1'b0, 1'b0);
    bus(1'b1, HBI_OFS_CTRL_ONE, {30'h0, m});
    step(4'h8, 1'b0, 1'b0);
    cmp_out();
    step(4'hC, 1'b0, 1'b0);
    cmp_out();
    mode_r = m;
    step(4'h8, 1'b0, 1'b0);
    cmp_out();
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(19669));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(1'b0, HBI_OFS_CTRL_ONE, 32'h0);
    cmp_reg(got, {30'h0, HBI_MODE_RESET});
    bus(1'b0, HBI_OFS_CTRL_THREE, 32'h0);
    cmp_reg(got, 32'h0);
    bus(1'b0, 4'hC, 32'h0);
    cmp_reg(got, 32'h0);
    step(4'hA, 1'b0, 1'b0);
    cmp_out();
    // Sweep every mode with random pins, faults and float bits
    for (int i = 0; i < 4; i++) begin
      latch(2'(i + 2));
      fl = 2'($urandom);
      bus(1'b1, HBI_OFS_CTRL_THREE, {30'h0, fl});
      repeat (12) begin
        r = 10'($urandom);
        step({r[7:5] != 3'h0, r[4:2] == 3'h0, r[1:0]}, r[8] && r[9], r[9] && !r[8]);
        cmp_out();
      end
    end
    step(4'h3, 1'b1, 1'b0);
    cmp_out();
    step(4'h8, 1'b0, 1'b0);
    // Forward drive in PWM mode: A stays high, B toggles every four edges
    fwd <= 1'b1;
    repeat (8) @(posedge clk);
    n = 0;
    r = {8'h0, oa & oea, ob};
    repeat (40) begin
      @(posedge clk);
      r[1] = r[1] & oa & oea;
      if (ob !== r[0]) n++;
      r[0] = ob;
    end
    cmp_reg({31'h0, r[1]}, 32'h1);
    cmp_reg(32'(n), 32'd10);
    results();
  end
endmodule
`default_nettype wire
